// [rtl/pd_engine_pkg.sv]
// Contract
// - Preset current level advertised on attach
// - Changed current level advertised immediately
// - Ra detection reports level code per setting
// - Rd attach/detach at mid threshold
// - Rd attach/detach at high threshold
// - Flag comparator and bus voltage changes
// - 48-byte transmit, 80-byte receive buffers
// - Tokens in transmit buffer govern sending
// - Tokens switch line driver on, off
// - Valid packet stored with its CRC
// - Line activity starts oscillator, then receive
// - Flag activity and good CRC
// - Own CRC check gates good flag
// - Auto GoodCRC when enabled, option clear
// - Resend same message up to count
// - Resend failure flag, then soft reset
// - GoodCRC id zero flags soft reset success
// - Soft reset resends, id zero, fail flag
// - Power-on loads register defaults
// - Software reset bit resets device
package pd_engine_pkg;
  // ==========================================
  // Timing
  localparam int CLK_NS = 25;
  localparam int ACK_WAIT_NS = 1100000;
  localparam int ACK_WAIT_CYC = ACK_WAIT_NS / CLK_NS;
  // ==========================================
  // Sizes and map
  localparam int TX_DEPTH = 48;
  localparam int RX_DEPTH = 80;
  localparam int AW = 5;
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_DAC = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ = 5'h0c;
  localparam logic [4:0] OFS_TXF = 5'h10;
  localparam logic [4:0] OFS_RXF = 5'h14;
  localparam int SWRST_BIT = 8;
  localparam int TOKEN_BIT = 8;
  localparam int EMPTY_BIT = 8;
  localparam logic [7:0] CFG_RST = 8'hc1;
  localparam logic [5:0] DAC_RST = 6'h00;
  // ==========================================
  // Flags
  localparam int IRQ_W = 7;
  localparam int IRQ_COMP = 0;
  localparam int IRQ_VBUS = 1;
  localparam int IRQ_ACT = 2;
  localparam int IRQ_CRC = 3;
  localparam int IRQ_RFAIL = 4;
  localparam int IRQ_TXOK = 5;
  localparam int IRQ_SFAIL = 6;
  // ==========================================
  // Line levels and protocol values
  localparam logic [5:0] LVL_TH0 = 6'h0a;
  localparam logic [5:0] LVL_TH1 = 6'h13;
  localparam logic [5:0] LVL_TH2 = 6'h26;
  localparam logic [7:0] TOK_TXON = 8'ha1;
  localparam logic [7:0] TOK_TXOFF = 8'hfe;
  localparam logic [4:0] MSG_GOODCRC = 5'h01;
  localparam logic [4:0] MSG_SOFTRST = 5'h0d;
  localparam logic [1:0] SPEC_REV = 2'h1;
  localparam logic PWR_ROLE = 1'b1;
  localparam int GEN_LEN = 2;
  localparam int MIN_PKT = 6;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  // ==========================================
  // Types
  typedef struct packed {
    logic [1:0] resend_count_total;
    logic auto_soft_reset;
    logic auto_retry;
    logic auto_pre;
    logic auto_ack;
    logic [1:0] source_current_level;
  } cfg_s;
  typedef struct packed {
    logic drive;
    logic valid;
    logic [7:0] data;
  } line_tx_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } tx_state_e;
endpackage

// [rtl/pd_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module pd_engine
  import pd_engine_pkg::*;
#(
  parameter int ACK_WAIT = ACK_WAIT_CYC,
  parameter int TXD = TX_DEPTH,
  parameter int RXD = RX_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CC sensing
  input wire logic [5:0] cc_sense,
  input wire logic vbus_ok_in,
  output logic [5:0] dac_code,
  output logic [1:0] cc_adv,
  // Line receive
  input wire logic line_active,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  output logic osc_en,
  // Line transmit
  input wire logic tx_ready,
  output line_tx_s tx_out
);
  localparam int TW = $clog2(TXD + 1);
  localparam int RW = $clog2(RXD + 1);
  localparam int PW = $clog2(RXD);
  localparam int MW = $clog2(ACK_WAIT + 1);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [PW-1:0] inc_rx(input logic [PW-1:0] p);
    return (p == PW'(RXD - 1)) ? '0 : p + PW'(1);
  endfunction

  function automatic logic [1:0] level_of(input logic [5:0] v);
    if (v < LVL_TH0) begin
      return 2'h0;
    end else if (v < LVL_TH1) begin
      return 2'h1;
    end else if (v < LVL_TH2) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction

  // ==========================================
  // Reset and bus slave
  cfg_s cfg_q;
  logic [5:0] dac_q;
  logic [IRQ_W-1:0] irq_q;
  logic srst_q;
  logic rst;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic wr_en;
  logic rd_en;
  assign rst = sys_rst | srst_q;
  assign wr_en = avs_write & ~wait_q;
  assign rd_en = avs_read & ~wait_q;
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // One wait state, then release for exactly one edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else if (wr_en | rd_en) begin
      wait_q <= 1'b1;
    end else if (avs_read | avs_write) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (avs_read & wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Self-clearing; held off by power-on reset only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_en && avs_address == OFS_CFG && avs_writedata[SWRST_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= cfg_s'(CFG_RST);
      dac_q <= DAC_RST;
    end else if (wr_en && avs_address == OFS_CFG) begin
      cfg_q <= cfg_s'(avs_writedata[7:0]);
    end else if (wr_en && avs_address == OFS_DAC) begin
      dac_q <= avs_writedata[5:0];
    end
  end
  // Advertisement follows the setting with no attach gating
  assign cc_adv = cfg_q.source_current_level;
  assign dac_code = dac_q;

  // ==========================================
  // CC and bus voltage sensing
  logic [1:0] lvl_q;
  logic comp_q;
  logic vbus_q;
  logic act_q;
  logic comp_now;
  assign comp_now = cc_sense > dac_q;
  always_ff @(posedge clk_sys) begin
    // Track the pins in reset so release shows no false change
    if (rst) begin
      lvl_q <= '0;
      comp_q <= comp_now;
      vbus_q <= vbus_ok_in;
      act_q <= line_active;
    end else begin
      lvl_q <= level_of(cc_sense);
      comp_q <= comp_now;
      vbus_q <= vbus_ok_in;
      act_q <= line_active;
    end
  end

  // ==========================================
  // Transmit buffer
  logic [8:0] tx_mem [TXD];
  logic [TW-1:0] tx_cnt_q;
  logic tx_hold_q;
  logic tx_push;
  tx_state_e st_q;
  assign tx_push = wr_en && avs_address == OFS_TXF && !tx_hold_q && tx_cnt_q < TW'(TXD);

  always_ff @(posedge clk_sys) begin
    if (tx_push) begin
      tx_mem[tx_cnt_q[TW-1:0]] <= avs_writedata[8:0];
    end
  end

  // Closing token marks the burst complete and locks the buffer
  always_ff @(posedge clk_sys) begin
    if (rst || st_q == ST_DONE) begin
      tx_cnt_q <= '0;
      tx_hold_q <= 1'b0;
    end else if (tx_push) begin
      tx_cnt_q <= tx_cnt_q + TW'(1);
      tx_hold_q <= avs_writedata[TOKEN_BIT] && avs_writedata[7:0] == TOK_TXOFF;
    end
  end

  // ==========================================
  // Receive buffer
  logic [7:0] rx_mem [RXD];
  logic [PW-1:0] rx_wp_q;
  logic [PW-1:0] rx_base_q;
  logic [PW-1:0] rx_rp_q;
  logic [RW-1:0] rx_cnt_q;
  logic [RW-1:0] len_q;
  logic [31:0] crc_q;
  logic drop_q;
  logic inpkt_q;
  logic [15:0] hdr_q;
  logic good_q;
  logic rx_pop;
  logic rx_room;
  logic rx_good;
  logic gcrc_rx;
  assign rx_pop = rd_en && avs_address == OFS_RXF && rx_cnt_q != '0;
  // One spare bit so a full buffer plus a long packet cannot wrap
  assign rx_room = ({1'b0, rx_cnt_q} + {1'b0, len_q}) < (RW + 1)'(RXD);
  assign rx_good = rx_eop && inpkt_q && crc_q == CRC_RESIDUE && !drop_q
    && len_q >= RW'(MIN_PKT);
  assign gcrc_rx = good_q && hdr_q[4:0] == MSG_GOODCRC && hdr_q[14:12] == 3'h0;

  always_ff @(posedge clk_sys) begin
    if (rx_valid && inpkt_q && rx_room) begin
      rx_mem[rx_wp_q] <= rx_data;
    end
  end

  // Packet bytes stay tentative until the check passes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_wp_q <= '0;
      rx_base_q <= '0;
      len_q <= '0;
      crc_q <= CRC_INIT;
      drop_q <= 1'b0;
      inpkt_q <= 1'b0;
      hdr_q <= '0;
    end else if (rx_sop) begin
      rx_wp_q <= rx_base_q;
      len_q <= '0;
      crc_q <= CRC_INIT;
      drop_q <= 1'b0;
      inpkt_q <= 1'b1;
    end else if (rx_eop && inpkt_q) begin
      inpkt_q <= 1'b0;
      len_q <= '0;
      if (rx_good) begin
        rx_base_q <= rx_wp_q;
      end else begin
        rx_wp_q <= rx_base_q;
      end
    end else if (rx_valid && inpkt_q) begin
      crc_q <= crc_byte(crc_q, rx_data);
      if (!rx_room) begin
        drop_q <= 1'b1;
      end else begin
        rx_wp_q <= inc_rx(rx_wp_q);
        len_q <= len_q + RW'(1);
        if (len_q == RW'(0)) begin
          hdr_q[7:0] <= rx_data;
        end else if (len_q == RW'(1)) begin
          hdr_q[15:8] <= rx_data;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
      good_q <= 1'b0;
    end else begin
      good_q <= rx_good;
      if (rx_pop) begin
        rx_rp_q <= inc_rx(rx_rp_q);
      end
      rx_cnt_q <= rx_cnt_q + (rx_good ? len_q : RW'(0)) - (rx_pop ? RW'(1) : RW'(0));
    end
  end

  // ==========================================
  // Automatic acknowledge request
  logic ack_pend_q;
  logic [2:0] ack_id_q;
  logic ack_take;
  assign ack_take = ack_pend_q && (st_q == ST_IDLE || st_q == ST_WAIT);
  // Set wins over the take in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_pend_q <= 1'b0;
      ack_id_q <= '0;
    end else if (good_q && !gcrc_rx && cfg_q.auto_ack && !cfg_q.auto_pre) begin
      ack_pend_q <= 1'b1;
      ack_id_q <= hdr_q[11:9];
    end else if (ack_take) begin
      ack_pend_q <= 1'b0;
    end
  end

  // ==========================================
  // Transmit sequencer
  logic gcrc_q;
  logic sr_q;
  logic ret_wait_q;
  logic [TW-1:0] idx_q;
  logic [1:0] retry_q;
  logic [MW-1:0] tmr_q;
  logic ev_txok_q;
  logic ev_rfail_q;
  logic ev_sfail_q;
  line_tx_s tx_q;
  logic gen;
  logic at_end;
  logic step;
  logic [8:0] item;
  logic [15:0] gen_hdr;
  logic ack_ok;
  logic can_retry;
  assign gen = gcrc_q | sr_q;
  assign step = st_q == ST_SEND && (!tx_q.valid || tx_ready);
  // Only an id-zero GoodCRC closes the soft reset
  assign ack_ok = gcrc_rx && (!sr_q || hdr_q[11:9] == 3'h0);
  assign can_retry = (cfg_q.auto_retry | sr_q) && retry_q < cfg_q.resend_count_total;
  assign tx_out = tx_q;

  always_comb begin
    gen_hdr = {1'b0, 3'h0, gcrc_q ? ack_id_q : 3'h0, PWR_ROLE, SPEC_REV, 1'b0,
      gcrc_q ? MSG_GOODCRC : MSG_SOFTRST};
    if (gen) begin
      at_end = idx_q >= TW'(GEN_LEN);
      item = {1'b0, idx_q[0] ? gen_hdr[15:8] : gen_hdr[7:0]};
    end else begin
      at_end = idx_q == tx_cnt_q;
      item = (idx_q < TW'(TXD)) ? tx_mem[idx_q] : '0;
    end
  end

  // Payload is replayed from the buffer, never consumed, so a resend is exact
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_q <= '0;
    end else begin
      if (tx_q.valid && tx_ready) begin
        tx_q.valid <= 1'b0;
      end
      if (step) begin
        if (at_end) begin
          tx_q.drive <= 1'b0;
        end else if (!gen && item[TOKEN_BIT]) begin
          if (item[7:0] == TOK_TXON) begin
            tx_q.drive <= 1'b1;
          end else if (item[7:0] == TOK_TXOFF) begin
            tx_q.drive <= 1'b0;
          end
        end else begin
          tx_q.drive <= tx_q.drive | gen;
          tx_q.valid <= 1'b1;
          tx_q.data <= item[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      gcrc_q <= 1'b0;
      sr_q <= 1'b0;
      ret_wait_q <= 1'b0;
      idx_q <= '0;
      retry_q <= '0;
      tmr_q <= '0;
      ev_txok_q <= 1'b0;
      ev_rfail_q <= 1'b0;
      ev_sfail_q <= 1'b0;
    end else begin
      ev_txok_q <= 1'b0;
      ev_rfail_q <= 1'b0;
      ev_sfail_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          idx_q <= '0;
          if (ack_pend_q) begin
            gcrc_q <= 1'b1;
            ret_wait_q <= 1'b0;
            st_q <= ST_SEND;
          end else if (tx_hold_q) begin
            sr_q <= 1'b0;
            retry_q <= '0;
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (step && at_end) begin
            idx_q <= '0;
            if (gcrc_q) begin
              gcrc_q <= 1'b0;
              st_q <= ret_wait_q ? ST_WAIT : ST_IDLE;
            end else begin
              tmr_q <= '0;
              st_q <= ST_WAIT;
            end
          end else if (step) begin
            idx_q <= idx_q + TW'(1);
          end
        end
        ST_WAIT: begin
          tmr_q <= tmr_q + MW'(1);
          if (ack_pend_q) begin
            gcrc_q <= 1'b1;
            ret_wait_q <= 1'b1;
            idx_q <= '0;
            st_q <= ST_SEND;
          end else if (ack_ok) begin
            ev_txok_q <= 1'b1;
            st_q <= ST_DONE;
          end else if (tmr_q >= MW'(ACK_WAIT - 1)) begin
            idx_q <= '0;
            if (can_retry) begin
              retry_q <= retry_q + 2'h1;
              st_q <= ST_SEND;
            end else if (!sr_q) begin
              ev_rfail_q <= 1'b1;
              if (cfg_q.auto_soft_reset) begin
                sr_q <= 1'b1;
                retry_q <= '0;
                st_q <= ST_SEND;
              end else begin
                st_q <= ST_DONE;
              end
            end else begin
              ev_sfail_q <= 1'b1;
              st_q <= ST_DONE;
            end
          end
        end
        default: begin
          sr_q <= 1'b0;
          retry_q <= '0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Oscillator request and status flags
  logic osc_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= line_active | inpkt_q | (st_q != ST_IDLE);
    end
  end
  assign osc_en = osc_q;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_COMP] = comp_now != comp_q;
    irq_set[IRQ_VBUS] = vbus_ok_in != vbus_q;
    irq_set[IRQ_ACT] = line_active & ~act_q;
    irq_set[IRQ_CRC] = good_q;
    irq_set[IRQ_RFAIL] = ev_rfail_q;
    irq_set[IRQ_TXOK] = ev_txok_q;
    irq_set[IRQ_SFAIL] = ev_sfail_q;
    irq_clr = (wr_en && avs_address == OFS_IRQ) ? avs_writedata[IRQ_W-1:0] : '0;
  end

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q <= '0;
    end else begin
      irq_q <= (irq_q & ~irq_clr) | irq_set;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      OFS_CFG: rd_mux[7:0] = cfg_q;
      OFS_DAC: rd_mux[5:0] = dac_q;
      OFS_STAT: rd_mux[5+RW-1:0] = {rx_cnt_q, st_q != ST_IDLE, vbus_q, comp_q, lvl_q};
      OFS_IRQ: rd_mux[IRQ_W-1:0] = irq_q;
      OFS_RXF: rd_mux[EMPTY_BIT:0] = {rx_cnt_q == '0, rx_mem[rx_rp_q]};
      default: rd_mux = '0;
    endcase
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_ack_seen;
    st_q == ST_WAIT && !ack_pend_q && ack_ok;
  endsequence

  AST_ADV_NOW: assert property (wr_en && avs_address == OFS_CFG |=>
    cc_adv == $past(avs_writedata[1:0])) else $error("advertisement not updated");
  AST_RA_LEVEL: assert property (cc_sense < LVL_TH0 |=> lvl_q == 2'h0)
    else $error("low level code wrong");
  AST_COMP_LOW: assert property (cc_sense <= dac_q |=> !comp_q)
    else $error("comparator high below threshold");
  AST_COMP_HIGH: assert property (cc_sense > dac_q ##1 $stable(dac_q) |-> comp_q)
    else $error("comparator low above threshold");
  AST_RETRY_MAX: assert property (retry_q <= cfg_q.resend_count_total)
    else $error("resend count exceeded");
  AST_SR_ID0: assert property (step && sr_q && !gcrc_q && idx_q == TW'(1)
    |=> tx_q.valid && tx_q.data[3:1] == 3'h0) else $error("soft reset id not zero");
  AST_TXOK: assert property (s_ack_seen |-> ##2 irq_q[IRQ_TXOK])
    else $error("success flag missing");
  AST_BAD_CRC: assert property (rx_eop && inpkt_q && crc_q != CRC_RESIDUE
    |=> !good_q ##1 !irq_q[IRQ_CRC] || $past(irq_q[IRQ_CRC], 2))
    else $error("bad packet flagged good");
  AST_OSC_ON: assert property (line_active |=> osc_en)
    else $error("oscillator not requested");
  AST_SWRST: assert property (disable iff (sys_rst) srst_q |=>
    cfg_q == cfg_s'(CFG_RST) && st_q == ST_IDLE) else $error("soft reset ineffective");
endmodule
`default_nettype wire

// [bench/pd_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pd_partner
  import pd_engine_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Knobs
  input wire logic [7:0] ack_at,
  input wire logic slow,
  // Engine side
  input wire line_tx_s tx_out,
  input wire logic osc_en,
  output logic tx_ready,
  output logic line_active,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sop,
  output logic rx_eop
);
  // ==========================================
  // Frame capture
  logic [7:0] frames_q;
  logic [3:0] nb_q;
  logic [3:0] tick_q;
  logic drive_q;
  logic osc_seen;
  logic [7:0] hdr0 [0:15];
  logic [7:0] hdr1 [0:15];
  logic [7:0] pkt [0:5];
  // Stalls half the time when slow
  assign tx_ready = slow ? tick_q[1] : 1'b1;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frames_q <= 8'h00;
      nb_q <= 4'h0;
      tick_q <= 4'h0;
      drive_q <= 1'b0;
      osc_seen <= 1'b0;
    end else begin
      tick_q <= tick_q + 4'h1;
      drive_q <= tx_out.drive;
      if (line_active && osc_en) osc_seen <= 1'b1;
      if (tx_out.valid && tx_ready) begin
        if (nb_q == 4'h0) hdr0[frames_q[3:0]] <= tx_out.data;
        if (nb_q == 4'h1) hdr1[frames_q[3:0]] <= tx_out.data;
        nb_q <= nb_q + 4'h1;
      end
      if (drive_q && !tx_out.drive) begin
        frames_q <= frames_q + 8'h01;
        nb_q <= 4'h0;
      end
    end
  end
  // ==========================================
  // Packet sender
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic bad);
    logic [31:0] c;
    c = 32'hffffffff;
    pkt[0] = b0;
    pkt[1] = b1;
    for (int i = 0; i < 2; i++) begin
      c = c ^ {24'h0, pkt[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    c = ~c;
    if (bad) c[0] = ~c[0];
    for (int i = 0; i < 4; i++) pkt[2 + i] = c[8 * i +: 8];
    line_active <= 1'b1;
    @(posedge clk_sys);
    rx_sop <= 1'b1;
    @(posedge clk_sys);
    rx_sop <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rx_valid <= 1'b1;
      rx_data <= pkt[i];
      @(posedge clk_sys);
    end
    // Stale byte inverted so nothing reads it as data
    rx_valid <= 1'b0;
    rx_data <= ~pkt[5];
    rx_eop <= 1'b1;
    @(posedge clk_sys);
    rx_eop <= 1'b0;
    repeat (2) @(posedge clk_sys);
    line_active <= 1'b0;
  endtask
  initial begin
    line_active = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_sop = 1'b0;
    rx_eop = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (drive_q && !tx_out.drive && frames_q == ack_at) begin
        repeat (10) @(posedge clk_sys);
        send({SPEC_REV, 1'b0, MSG_GOODCRC}, 8'h00, 1'b0);
      end
    end
  end
endmodule
`default_nettype wire

// [bench/pd_engine_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pd_engine_tb_top;
  import pd_engine_pkg::*;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, vbus_ok_in, osc_en, slow;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [5:0] cc_sense, dac_code;
  logic [1:0] cc_adv;
  logic line_active, rx_valid, rx_sop, rx_eop, tx_ready;
  logic [7:0] rx_data, ack_at, f0;
  line_tx_s tx_out;
  int mismatches, n_compared;
  logic [5:0] ra [0:3] = '{6'h00, 6'h05, 6'h0e, 6'h1a};
  logic [14:0] rc [0:4] = '{{2'b01, 6'h26, 6'h20, 1'b0}, {2'b01, 6'h26, 6'h3f, 1'b1},
    {2'b10, 6'h26, 6'h20, 1'b0}, {2'b11, 6'h3e, 6'h30, 1'b0}, {2'b11, 6'h3e, 6'h3f, 1'b1}};
  pd_engine #(.ACK_WAIT(50)) u_pd_engine (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cc_sense(cc_sense), .vbus_ok_in(vbus_ok_in),
    .dac_code(dac_code), .cc_adv(cc_adv), .line_active(line_active), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop), .osc_en(osc_en),
    .tx_ready(tx_ready), .tx_out(tx_out));
  pd_partner u_pd_partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .ack_at(ack_at),
    .slow(slow), .tx_out(tx_out), .osc_en(osc_en), .tx_ready(tx_ready),
    .line_active(line_active), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sop(rx_sop),
    .rx_eop(rx_eop));
  // ==========================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    $display("unexpected at %0t: timeout", $time);
    stop_test;
  end
  // ==========================================
  // Bus and check tasks
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
      input string s);
    bus(1'b0, a, 32'h0);
    chk(q & m, e, s);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_IRQ, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 400);
    if (q[b] !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: flag %0d never set", $time, b);
    end
  endtask
  task automatic txmsg;
    bus(1'b1, OFS_TXF, 32'h1a1);
    bus(1'b1, OFS_TXF, 32'h12);
    bus(1'b1, OFS_TXF, 32'h34);
    bus(1'b1, OFS_TXF, 32'h1fe);
  endtask
  task automatic stop_test;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    {sys_rst, avs_read, avs_write, vbus_ok_in, slow} = 5'b10000;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    cc_sense = 6'h3f;
    ack_at = 8'hff;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFS_CFG, 32'hff, 32'hc1, "cfg default");
    rd(OFS_DAC, 32'h3f, 32'h0, "dac default");
    rd(OFS_IRQ, 32'h7f, 32'h0, "irq default");
    chk(32'(cc_adv), 32'h1, "adv default");
    rd(5'h18, 32'hffffffff, 32'h0, "unmapped");
    for (int i = 1; i < 4; i++) begin
      bus(1'b1, OFS_CFG, 32'hc0 | i);
      cc_sense <= ra[i];
      rd(OFS_STAT, 32'h3, i - 1, "ra level");
      chk(32'(cc_adv), i, "adv level");
    end
    for (int j = 0; j < 5; j++) begin
      bus(1'b1, OFS_CFG, 32'hc0 | rc[j][14:13]);
      bus(1'b1, OFS_DAC, 32'(rc[j][12:7]));
      cc_sense <= rc[j][6:1];
      rd(OFS_STAT, 32'h4, 32'(rc[j][0]) << 2, "rd compare");
      chk(32'(dac_code), 32'(rc[j][12:7]), "dac out");
    end
    rd(OFS_IRQ, 32'h1, 32'h1, "comp irq");
    bus(1'b1, OFS_IRQ, 32'h7f);
    vbus_ok_in <= 1'b1;
    rd(OFS_IRQ, 32'h2, 32'h2, "vbus irq");
    bus(1'b1, OFS_IRQ, 32'h7f);
    rd(OFS_IRQ, 32'h7f, 32'h0, "irq cleared");
    // Good packet with auto acknowledge
    bus(1'b1, OFS_CFG, 32'hc5);
    f0 = u_pd_partner.frames_q;
    u_pd_partner.send(8'h6f, 8'h12, 1'b0);
    poll(IRQ_CRC);
    rd(OFS_IRQ, 32'hc, 32'hc, "rx irqs");
    chk(32'(u_pd_partner.osc_seen), 32'h1, "osc");
    for (int n = 0; n < 100 && u_pd_partner.frames_q == f0; n++) @(posedge clk_sys);
    chk(32'(u_pd_partner.hdr0[f0[3:0]][4:0]), 32'(MSG_GOODCRC), "goodcrc");
    for (int i = 0; i < 6; i++) rd(OFS_RXF, 32'h1ff, 32'(u_pd_partner.pkt[i]), "rx byte");
    rd(OFS_RXF, 32'h100, 32'h100, "rx empty");
    // Corrupted CRC is dropped
    bus(1'b1, OFS_IRQ, 32'h7f);
    f0 = u_pd_partner.frames_q;
    u_pd_partner.send(8'h6f, 8'h12, 1'b1);
    repeat (60) @(posedge clk_sys);
    rd(OFS_IRQ, 32'h8, 32'h0, "bad crc irq");
    rd(OFS_RXF, 32'h100, 32'h100, "bad crc dropped");
    chk(32'(u_pd_partner.frames_q), 32'(f0), "no ack on bad");
    // Acknowledged message
    bus(1'b1, OFS_CFG, 32'hd1);
    bus(1'b1, OFS_IRQ, 32'h7f);
    f0 = u_pd_partner.frames_q;
    ack_at <= f0;
    txmsg;
    poll(IRQ_TXOK);
    chk(32'(u_pd_partner.hdr0[f0[3:0]]), 32'h12, "tx byte0");
    chk(32'(u_pd_partner.hdr1[f0[3:0]]), 32'h34, "tx byte1");
    repeat (150) @(posedge clk_sys);
    chk(32'(u_pd_partner.frames_q - f0), 32'h1, "no resend");
    // Never acknowledged, slow line
    bus(1'b1, OFS_CFG, 32'hf1);
    slow <= 1'b1;
    ack_at <= 8'hff;
    bus(1'b1, OFS_IRQ, 32'h7f);
    f0 = u_pd_partner.frames_q;
    txmsg;
    poll(IRQ_SFAIL);
    rd(OFS_IRQ, 32'h70, 32'h50, "fail irqs");
    chk(32'(u_pd_partner.frames_q - f0), 32'h8, "frame count");
    for (int k = 0; k < 8; k++) begin
      if (k < 4)
        chk(32'(u_pd_partner.hdr0[4'(f0 + k)]), 32'h12, "resend");
      else begin
        chk(32'(u_pd_partner.hdr0[4'(f0 + k)][4:0]), 32'(MSG_SOFTRST), "soft");
        chk(32'(u_pd_partner.hdr1[4'(f0 + k)][3:1]), 32'h0, "soft id");
      end
    end
    // Soft reset acknowledged on its one retry
    slow <= 1'b0;
    bus(1'b1, OFS_CFG, 32'h71);
    bus(1'b1, OFS_IRQ, 32'h7f);
    f0 = u_pd_partner.frames_q;
    ack_at <= 8'(f0 + 8'h03);
    txmsg;
    poll(IRQ_TXOK);
    rd(OFS_IRQ, 32'h70, 32'h30, "soft ok irqs");
    chk(32'(u_pd_partner.frames_q - f0), 32'h4, "count restart");
    chk(32'(u_pd_partner.hdr0[4'(f0 + 3)][4:0]), 32'(MSG_SOFTRST), "soft retry");
    // Software reset
    bus(1'b1, OFS_CFG, 32'h100);
    rd(OFS_CFG, 32'hff, 32'hc1, "sw reset cfg");
    rd(OFS_DAC, 32'h3f, 32'h0, "sw reset dac");
    chk(32'(cc_adv), 32'h1, "sw reset adv");
    stop_test;
  end
endmodule
`default_nettype wire
